// [verilog/partner_regs_pkg.sv]
// constants for the auto-negotiation partner ability register bank
// What this block does
// - Negotiation sends local capabilities including selector field
// - Local selector field resets to IEEE 802.3 code
// - Partner register loads from received base page while negotiation enabled
// - Partner next page bit mirrors received word
// - Partner acknowledge bit mirrors received word
// - Partner remote fault bit mirrors received word
// - Partner technology bits mirror received word
// - Partner 100Base-T4 bit always reads zero
// - Partner reserved bits always read zero
// - Partner selector holds received selector code
// - Override-gated bits change only when override set
// - Negotiation disabled uses forced rate and duplex
package partner_regs_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 16;
    // register indices, byte address is four times the index
    localparam logic [5:0]  IDX_CTRL      = 6'h00;
    localparam logic [5:0]  IDX_STAT      = 6'h01;
    localparam logic [5:0]  IDX_ADV       = 6'h04;
    localparam logic [5:0]  IDX_PARTNER   = 6'h05;
    localparam logic [5:0]  IDX_OVR       = 6'h10;
    localparam logic [5:0]  IDX_IRQ_STAT  = 6'h18;
    localparam logic [5:0]  IDX_IRQ_MASK  = 6'h19;
    // control and status fields
    localparam int          AN_EN_BIT     = 12;
    localparam int          RATE_BIT      = 13;
    localparam int          DUPLEX_BIT    = 8;
    localparam int          AN_DONE_BIT   = 5;
    localparam int          OVR_BIT       = 15;
    // base page code word layout, shared by advertised and partner words
    localparam int          NP_BIT        = 15;
    localparam int          ACK_BIT       = 14;
    localparam int          RF_BIT        = 13;
    localparam int          RSV_MSB       = 12;
    localparam int          RSV_LSB       = 10;
    localparam int          T4_BIT        = 9;
    localparam int          TECH_MSB      = 8;
    localparam int          TECH_LSB      = 5;
    localparam int          SEL_MSB       = 4;
    localparam int          SEL_LSB       = 0;
    // reset values and codes
    localparam logic [15:0] CTRL_RST      = 16'h1000;
    localparam logic [15:0] PARTNER_RST   = 16'h0000;
    localparam logic [3:0]  TECH_RST      = 4'hf;
    localparam logic [2:0]  RSV_RST       = 3'h0;
    localparam logic [0:0]  ACK_RST       = 1'h0;
    localparam logic [4:0]  SEL_802_3     = 5'h01;
    localparam logic [4:0]  SEL_802_9     = 5'h02;
    // interrupt status layout
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_PAGE_BIT  = 0;
    localparam int          IRQ_DONE_BIT  = 1;
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    // bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// [verilog/cw_field.sv]
// register field that takes writes only while the override bit is set
`timescale 1ns/1ps
module gated_field #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         aclk,     // core clock
    input  wire logic         aresetn,  // synchronous reset, active low
    input  wire logic         wr_en,    // software write to this field
    input  wire logic         override, // override bit state
    input  wire logic [W-1:0] wdata,    // merged write value
    output logic      [W-1:0] q         // field value
);
    logic [W-1:0] q_d;

    always_comb begin
        q_d = q;
        if (wr_en && override) begin
            q_d = wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST;
        end else begin
            q <= q_d;
        end
    end
endmodule // gated_field

// [verilog/autoneg_partner_ability_regs.sv]
// partner ability capture, local advertisement and axi4-lite register bank
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module autoneg_partner_ability_regs (
    input  wire logic                                aclk,               // core clock
    input  wire logic                                aresetn,            // synchronous reset, active low
    input  wire logic [partner_regs_pkg::ADDR_W-1:0] s_axi_awaddr,       // write address
    input  wire logic                                s_axi_awvalid,      // write address valid
    output logic                                     s_axi_awready,      // write address ready
    input  wire logic [partner_regs_pkg::DATA_W-1:0] s_axi_wdata,        // write data
    input  wire logic [3:0]                          s_axi_wstrb,        // write byte strobes
    input  wire logic                                s_axi_wvalid,       // write data valid
    output logic                                     s_axi_wready,       // write data ready
    output logic      [1:0]                          s_axi_bresp,        // write response
    output logic                                     s_axi_bvalid,       // write response valid
    input  wire logic                                s_axi_bready,       // write response ready
    input  wire logic [partner_regs_pkg::ADDR_W-1:0] s_axi_araddr,       // read address
    input  wire logic                                s_axi_arvalid,      // read address valid
    output logic                                     s_axi_arready,      // read address ready
    output logic      [partner_regs_pkg::DATA_W-1:0] s_axi_rdata,        // read data
    output logic      [1:0]                          s_axi_rresp,        // read response
    output logic                                     s_axi_rvalid,       // read data valid
    input  wire logic                                s_axi_rready,       // read data ready
    input  wire logic                                rx_page_valid,      // base page received, one cycle
    input  wire logic [partner_regs_pkg::REG_W-1:0]  rx_page_word,       // received base page word
    input  wire logic                                an_complete,        // negotiation complete level
    output logic      [partner_regs_pkg::REG_W-1:0]  tx_code_word,       // code word to send
    output logic                                     an_enable_out,      // negotiation enabled
    output logic                                     forced_rate_100,    // forced 100 Mb/s when not negotiating
    output logic                                     forced_full_duplex, // forced full duplex when not negotiating
    output logic                                     partner_sel_ok,     // partner selector is 802.3
    output logic                                     irq                 // interrupt, level
);
    import partner_regs_pkg::*;

    // bus slave state
    logic        aw_have_q, aw_have_d;
    logic [5:0]  aw_idx_q, aw_idx_d;
    logic        w_have_q, w_have_d;
    logic [15:0] w_data_q, w_data_d;
    logic [1:0]  w_strb_q, w_strb_d;
    logic        awready_q, awready_d;
    logic        wready_q, wready_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        arready_q, arready_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // register state
    logic [15:0] ctrl_q, ctrl_d;
    logic        ovr_q, ovr_d;
    logic        adv_np_q, adv_np_d;
    logic        adv_rf_q, adv_rf_d;
    logic [3:0]  adv_tech_q, adv_tech_d;
    logic [15:0] partner_q, partner_d;
    logic [1:0]  irq_stat_q, irq_stat_d;
    logic [1:0]  irq_mask_q, irq_mask_d;
    logic        an_done_q;

    // output flops
    logic [15:0] tx_word_q, tx_word_d;
    logic        an_en_out_q, rate_q, duplex_q, sel_ok_q, irq_q;
    logic        rate_d, duplex_d, sel_ok_d, irq_d;

    // override-gated advertisement fields
    logic [4:0]  adv_sel;
    logic [2:0]  adv_rsv;
    logic [0:0]  adv_ack;
    logic [15:0] adv_word;
    logic [15:0] wr_merged;
    logic        wr_fire, ar_fire, an_en, page_take, done_evt;
    logic [1:0]  evt;

    // byte-lane merge of a 16-bit register with the write data
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    assign an_en     = ctrl_q[AN_EN_BIT];
    assign wr_fire   = aw_have_q && w_have_q && !bvalid_q;
    assign ar_fire   = s_axi_arvalid && arready_q;
    assign page_take = rx_page_valid && an_en;
    assign done_evt  = an_complete && !an_done_q;
    assign adv_word  = {adv_np_q, adv_ack, adv_rf_q, adv_rsv, 1'b0, adv_tech_q, adv_sel};

    // write data merged into whichever register is addressed
    always_comb begin
        case (aw_idx_q)
            IDX_CTRL:     wr_merged = merge(ctrl_q, w_data_q, w_strb_q);
            IDX_ADV:      wr_merged = merge(adv_word, w_data_q, w_strb_q);
            IDX_OVR:      wr_merged = merge({ovr_q, 15'h0000}, w_data_q, w_strb_q);
            IDX_IRQ_STAT: wr_merged = merge(16'h0000, w_data_q, w_strb_q);
            IDX_IRQ_MASK: wr_merged = merge({14'h0000, irq_mask_q}, w_data_q, w_strb_q);
            default:      wr_merged = 16'h0000;
        endcase
    end

    gated_field #(.W(5), .RST(SEL_802_3)) u_sel (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (wr_fire && aw_idx_q == IDX_ADV),
        .override (ovr_q),
        .wdata    (wr_merged[SEL_MSB:SEL_LSB]),
        .q        (adv_sel)
    );

    gated_field #(.W(3), .RST(RSV_RST)) u_rsv (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (wr_fire && aw_idx_q == IDX_ADV),
        .override (ovr_q),
        .wdata    (wr_merged[RSV_MSB:RSV_LSB]),
        .q        (adv_rsv)
    );

    gated_field #(.W(1), .RST(ACK_RST)) u_ack (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (wr_fire && aw_idx_q == IDX_ADV),
        .override (ovr_q),
        .wdata    (wr_merged[ACK_BIT:ACK_BIT]),
        .q        (adv_ack)
    );

    // axi4-lite channel handling
    always_comb begin
        aw_have_d = aw_have_q;
        aw_idx_d  = aw_idx_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_idx_d  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata[15:0];
            w_strb_d = s_axi_wstrb[1:0];
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            case (aw_idx_q)
                IDX_CTRL, IDX_STAT, IDX_ADV, IDX_PARTNER, IDX_OVR, IDX_IRQ_STAT, IDX_IRQ_MASK: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (ar_fire) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (s_axi_araddr[7:2])
                IDX_CTRL:     rdata_d = {16'h0000, ctrl_q};
                IDX_STAT:     rdata_d = {26'h0000000, an_complete, 5'h00};
                IDX_ADV:      rdata_d = {16'h0000, adv_word};
                IDX_PARTNER:  rdata_d = {16'h0000, partner_q};
                IDX_OVR:      rdata_d = {16'h0000, ovr_q, 15'h0000};
                IDX_IRQ_STAT: rdata_d = {30'h00000000, irq_stat_q};
                IDX_IRQ_MASK: rdata_d = {30'h00000000, irq_mask_q};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= 6'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 16'h0000;
            w_strb_q  <= 2'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h00000000;
        end else begin
            aw_have_q <= aw_have_d;
            aw_idx_q  <= aw_idx_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // register bank and partner capture
    always_comb begin
        ctrl_d     = ctrl_q;
        ovr_d      = ovr_q;
        adv_np_d   = adv_np_q;
        adv_rf_d   = adv_rf_q;
        adv_tech_d = adv_tech_q;
        irq_mask_d = irq_mask_q;
        partner_d  = partner_q;
        evt        = {done_evt, page_take};
        irq_stat_d = irq_stat_q;
        if (wr_fire) begin
            case (aw_idx_q)
                IDX_CTRL: ctrl_d = wr_merged;
                IDX_OVR:  ovr_d  = wr_merged[OVR_BIT];
                IDX_ADV: begin
                    adv_np_d   = wr_merged[NP_BIT];
                    adv_rf_d   = wr_merged[RF_BIT];
                    adv_tech_d = wr_merged[TECH_MSB:TECH_LSB];
                end
                IDX_IRQ_STAT: irq_stat_d = irq_stat_q & ~wr_merged[1:0];
                IDX_IRQ_MASK: irq_mask_d = wr_merged[1:0];
                default: ;
            endcase
        end
        irq_stat_d = irq_stat_d | evt; // set wins over clear
        if (page_take) begin
            partner_d = {rx_page_word[NP_BIT:RF_BIT], 3'h0, 1'b0,
                         rx_page_word[TECH_MSB:TECH_LSB],
                         rx_page_word[SEL_MSB:SEL_LSB]};
        end
        tx_word_d = an_en ? adv_word : 16'h0000;
        rate_d    = !ctrl_d[AN_EN_BIT] && ctrl_d[RATE_BIT];
        duplex_d  = !ctrl_d[AN_EN_BIT] && ctrl_d[DUPLEX_BIT];
        sel_ok_d  = partner_d[SEL_MSB:SEL_LSB] == SEL_802_3;
        irq_d     = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q      <= CTRL_RST;
            ovr_q       <= 1'b0;
            adv_np_q    <= 1'b0;
            adv_rf_q    <= 1'b0;
            adv_tech_q  <= TECH_RST;
            partner_q   <= PARTNER_RST;
            irq_stat_q  <= IRQ_RST;
            irq_mask_q  <= IRQ_RST;
            an_done_q   <= 1'b0;
            tx_word_q   <= 16'h0000;
            an_en_out_q <= 1'b0;
            rate_q      <= 1'b0;
            duplex_q    <= 1'b0;
            sel_ok_q    <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            ovr_q       <= ovr_d;
            adv_np_q    <= adv_np_d;
            adv_rf_q    <= adv_rf_d;
            adv_tech_q  <= adv_tech_d;
            partner_q   <= partner_d;
            irq_stat_q  <= irq_stat_d;
            irq_mask_q  <= irq_mask_d;
            an_done_q   <= an_complete;
            tx_word_q   <= tx_word_d;
            an_en_out_q <= ctrl_d[AN_EN_BIT];
            rate_q      <= rate_d;
            duplex_q    <= duplex_d;
            sel_ok_q    <= sel_ok_d;
            irq_q       <= irq_d;
        end
    end

    assign s_axi_awready      = awready_q;
    assign s_axi_wready       = wready_q;
    assign s_axi_bresp        = bresp_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_arready      = arready_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign s_axi_rvalid       = rvalid_q;
    assign tx_code_word       = tx_word_q;
    assign an_enable_out      = an_en_out_q;
    assign forced_rate_100    = rate_q;
    assign forced_full_duplex = duplex_q;
    assign partner_sel_ok     = sel_ok_q;
    assign irq                = irq_q;

    // checks
    logic [15:0] word_dly_q;
    always_ff @(posedge aclk) begin
        word_dly_q <= rx_page_word;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_page_taken;
        rx_page_valid && ctrl_q[AN_EN_BIT];
    endsequence

    sequence s_locked_adv_write;
        wr_fire && aw_idx_q == IDX_ADV && !ovr_q;
    endsequence

    a_partner_np: assert property (s_page_taken |=> partner_q[NP_BIT] == word_dly_q[NP_BIT])
        else $error("partner next page bit not taken from page");
    a_partner_ack: assert property (s_page_taken |=> partner_q[ACK_BIT] == word_dly_q[ACK_BIT])
        else $error("partner acknowledge bit not taken from page");
    a_partner_fault: assert property (s_page_taken |=> partner_q[RF_BIT] == word_dly_q[RF_BIT])
        else $error("partner remote fault bit not taken from page");
    a_partner_tech: assert property (s_page_taken |=>
            partner_q[TECH_MSB:TECH_LSB] == word_dly_q[TECH_MSB:TECH_LSB])
        else $error("partner technology bits not taken from page");
    a_partner_sel: assert property (s_page_taken |=>
            partner_q[SEL_MSB:SEL_LSB] == word_dly_q[SEL_MSB:SEL_LSB]
            ##1 partner_sel_ok == (partner_q[SEL_MSB:SEL_LSB] == SEL_802_3))
        else $error("partner selector not stored or flagged");
    a_t4_zero: assert property (partner_q[T4_BIT] == 1'b0 && tx_code_word[T4_BIT] == 1'b0)
        else $error("100base-t4 bit set");
    a_rsvd_zero: assert property (rvalid_q && $past(ar_fire) && $past(s_axi_araddr[7:2]) == IDX_PARTNER
            |-> s_axi_rdata[RSV_MSB:T4_BIT] == 4'h0)
        else $error("partner reserved bits read nonzero");
    a_gated_locked: assert property (s_locked_adv_write |=> $stable(adv_sel) && $stable(adv_rsv))
        else $error("override-gated field changed with override clear");
    a_an_off: assert property (!ctrl_q[AN_EN_BIT] |=> $stable(partner_q) && tx_code_word == 16'h0000)
        else $error("page captured or sent while negotiation disabled");
    a_tx_word: assert property (ctrl_q[AN_EN_BIT] |=> tx_code_word[SEL_MSB:SEL_LSB] == $past(adv_sel))
        else $error("sent selector differs from advertised");
    a_reset_zero: assert property ($rose(aresetn) |-> partner_q == 16'h0000 && adv_sel == SEL_802_3)
        else $error("reset values wrong");
    a_irq_level: assert property (irq == |(irq_stat_q & irq_mask_q))
        else $error("interrupt output does not follow masked status");
endmodule // autoneg_partner_ability_regs

// [tb/link_partner.sv]
// behavioural remote link partner that delivers received base pages
`timescale 1ns/1ps
module link_partner (
    input  wire logic        aclk,          // core clock
    input  wire logic        send,          // deliver one page
    input  wire logic [15:0] word,          // page to deliver
    output logic             rx_page_valid, // page strobe, one cycle
    output logic      [15:0] rx_page_word   // page word, scrambled when idle
);
    initial begin
        rx_page_valid = 1'b0;
        rx_page_word  = 16'h0000;
    end
    // idle word flips each cycle so a stale capture shows
    always @(posedge aclk) begin
        rx_page_valid <= send;
        rx_page_word  <= send ? word : ~rx_page_word;
    end
endmodule // link_partner

// [tb/testbench.sv]
// self-checking bench for the partner ability register bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    import partner_regs_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, send;
    logic        rx_page_valid, an_complete, an_enable_out, forced_rate_100, forced_full_duplex;
    logic        partner_sel_ok, irq;
    logic [15:0] rx_page_word, tx_code_word, word;
    int          n_errors = 0, total_checks = 0, cyc = 0;
    autoneg_partner_ability_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_page_valid, .rx_page_word, .an_complete, .tx_code_word, .an_enable_out, .forced_rate_100,
        .forced_full_duplex, .partner_sel_ok, .irq);
    link_partner i_partner (.aclk, .send, .word, .rx_page_valid, .rx_page_word);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic summarize;
        $display("errors=%0d checks=%0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] i, input logic [15:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic page(input logic [15:0] w);
        @(posedge aclk);
        send <= 1'b1;
        word <= w;
        @(posedge aclk);
        send <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic pg(input logic [15:0] w);
        page(w);
        rd(IDX_PARTNER);
        `CHK(d, {16'h0000, w[15:13], 3'b000, 1'b0, w[8:5], w[4:0]})
        `CHK(partner_sel_ok, w[4:0] == SEL_802_3)
    endtask
    task automatic t_reset;
        rd(IDX_PARTNER);
        `CHK(d, 32'h00000000)
        `CHK(tx_code_word, 16'h01e1)
        rd(IDX_ADV);
        `CHK(d[4:0], SEL_802_3)
    endtask
    task automatic t_pages;
        pg(16'hffff);
        pg(16'h0001);
        pg(16'h2002);
        pg(16'h5fe0);
        an_complete <= 1'b1;
        rd(IDX_STAT);
        `CHK(d[AN_DONE_BIT], 1'b1)
    endtask
    task automatic t_irq;
        `CHK(irq, 1'b0)
        wr(IDX_IRQ_STAT, 16'h0001);
        wr(IDX_IRQ_MASK, 16'h0001);
        `CHK(irq, 1'b0)
        pg(16'h8021);
        `CHK(irq, 1'b1)
        wr(IDX_IRQ_STAT, 16'h0001);
        @(posedge aclk);
        `CHK(irq, 1'b0)
        rd(IDX_IRQ_STAT);
        `CHK(d[1:0], 2'b10)
        wr(IDX_IRQ_MASK, 16'h0003);
        @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(IDX_IRQ_STAT, 16'h0002);
        @(posedge aclk);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_override;
        wr(IDX_ADV, 16'h01e2);
        rd(IDX_ADV);
        `CHK(d[4:0], SEL_802_3)
        wr(IDX_OVR, 16'h8000);
        wr(IDX_ADV, 16'h01e2);
        rd(IDX_ADV);
        `CHK(d[4:0], SEL_802_9)
        `CHK(tx_code_word[4:0], SEL_802_9)
        wr(IDX_ADV, 16'h01e1);
        wr(IDX_OVR, 16'h0000);
    endtask
    task automatic t_forced;
        wr(IDX_CTRL, 16'h2100);
        @(posedge aclk);
        `CHK({an_enable_out, forced_rate_100, forced_full_duplex, tx_code_word}, {3'b011, 16'h0000})
        page(16'h0001);
        rd(IDX_PARTNER);
        `CHK(d[15:0], 16'h8021)
        wr(IDX_CTRL, CTRL_RST);
        @(posedge aclk);
        `CHK({an_enable_out, tx_code_word}, {1'b1, 16'h01e1})
    endtask
    task automatic t_unmapped;
        wr(6'h3f, 16'h1234);
        `CHK(r, RESP_SLVERR)
        rd(6'h3f);
        `CHK({r, d}, {RESP_SLVERR, 32'h00000000})
        wr(IDX_PARTNER, 16'hffff);
        `CHK(r, RESP_OKAY)
        rd(IDX_PARTNER);
        `CHK(d[15:0], 16'h8021)
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, send, word, an_complete} = '0;
        s_axi_wstrb = 4'h3;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_pages();
        t_irq();
        t_override();
        t_forced();
        t_unmapped();
        summarize();
    end
endmodule // testbench
